//--- rtl/cbtc_map.vh
// Register map, action codes and card constants for the card transfer block
`ifndef CBTC_MAP_VH
`define CBTC_MAP_VH
`define CB_A_CMD    8'h00
`define CB_A_COPY   8'h04
`define CB_A_CTRL   8'h08
`define CB_A_LAST   8'h0c
`define CB_A_BROW   8'h10
`define CB_A_VFIRST 8'h14
`define CB_A_VMID   8'h18
`define CB_A_VLAST  8'h1c
`define CB_A_MODS   8'h20
`define CB_A_PAGES  8'h24
`define CB_B_RST    0
`define CB_B_INS    1
`define CB_B_MENU0  2
`define CB_B_UP     3
`define CB_B_DOWN   4
`define CB_K        16'h03e8
`define CB_C_BOOT   16'h07d1
`define CB_C_SUPCLR 16'h2553
`define CB_C_SUPSET 16'h25c2
`define CB_C_WPCLR  16'h2631
`define CB_C_WPSET  16'h26a0
`define CB_C_WIPE   16'h270f
`define CB_D_PAR    4'h3
`define CB_D_DIF    4'h4
`define CB_D_PRG    4'h5
`define CB_D_LOAD   4'h6
`define CB_D_ERASE  4'h7
`define CB_D_CMP    4'h8
`define CB_RO_NUM   10'h1f4
`define CB_BR_FREE  10'h3e8
`define CB_BR_TOTAL 10'h3e9
`define CB_BR_FLAGS 10'h3ea
`define CB_BR_ID    10'h3eb
`define CB_PG_MIN   16'h0100
`define CB_PG_MAX   16'h8000
`define CB_PG_RSV   16'h0002
`define CB_PG_PAR   16'h0010
`define CB_PG_DIF   16'h0004
`define CB_PG_PRG   16'h0008
`define CB_T_PAR    5'h01
`define CB_T_DIF    5'h02
`define CB_T_PRG    5'h03
`define CB_T_OPT    5'h12
`define CB_M_NONE   3'h0
`define CB_M_READ   3'h1
`define CB_M_PROG   3'h2
`define CB_M_AUTO   3'h3
`define CB_M_BOOT   3'h4
`define CB_TR_NONE  4'h0
`define CB_TR_MISS  4'h1
`define CB_TR_RO    4'h2
`define CB_TR_FULL  4'h3
`define CB_TR_CMP   4'h4
`define CB_TR_RTG   4'h5
`define CB_TR_OPT   4'h6
`define CB_MODS     32'h0000_0001
`define CB_VER      8'h01
`endif

//--- rtl/cbtc_top.v
// Card block command interpreter with AXI4-Lite register slave
`include "cbtc_map.vh"
// Notes on behaviour
// [RL1] Module-count register always reads one.
// [RL2] Last-loaded register, reset 0, holds last parameter or difference block loaded.
// [RL3] Browse index 0..1003; steps jump between present block numbers, 0 and 1000..1003.
// [RL4] Header fields of browsed block are viewable: number, type, mode, version, checksum.
// [RL5] Browse 1000 shows free card space in 16-byte pages.
// [RL6] Browse 1001 shows total usable card space in pages.
// [RL7] Browse 1002 shows flags: bit0 write-protect, bit1 warning suppression.
// [RL8] Browse 1003 shows the card product identifier.
// [RL9] First and last 16 card bytes never hold block data.
// [RL10] Card sizes from 4 KB to 512 KB are accepted.
// [RL11] Header holds flags and identifier; suppression blocks rating and option trips.
// [RL12] Browse returns to 0 on erases, new block, menu-0 change, new card.
// [RL13] Command code or copy mode acts only at a following drive reset.
// [RL14] Code 2001 stores difference data to block 1, replacing it.
// [RL15] 3yyy parameter file, 4yyy difference file, 5yyy user program to block yyy.
// [RL16] 6yyy loads block yyy into the drive; 7yyy erases block yyy.
// [RL17] 9555 clears warning suppression; 9666 sets it.
// [RL18] 9777 clears write-protect, 9888 sets it, 9999 erases whole card.
// [RL19] Read mode loads block 1 if parameter file; program mode stores block 1.
// [RL20] Auto and boot store block 1 only if copy mode changed since power-up.
// [RL21] 8yyy compares; match clears command, mismatch trips and keeps command.
// [RL22] Compare skips option-type blocks, type 18.
// [RL23] Blocks 500 and above cannot be created or erased.
// [RL24] Whole-card erase refused if write-protected or any block read-only.
// [RL25] Undefined codes leave card contents and flags unchanged.
module cbtc_top #(
  parameter [15:0] CARD_ID = 16'h0a5a  // Arbitrary product identifier
) (
  input  wire        ref_clk,         // Clock, 25 MHz
  input  wire        rst_n,           // Sync reset, active low
  input  wire        ce,              // Clock enable, freezes state when low
  input  wire [7:0]  s_axi_awaddr,    // Write address
  input  wire        s_axi_awvalid,   // Write address valid
  output reg         s_axi_awready,   // Write address ready
  input  wire [31:0] s_axi_wdata,     // Write data
  input  wire [3:0]  s_axi_wstrb,     // Write byte strobes
  input  wire        s_axi_wvalid,    // Write data valid
  output reg         s_axi_wready,    // Write data ready
  output reg  [1:0]  s_axi_bresp,     // Write response
  output reg         s_axi_bvalid,    // Write response valid
  input  wire        s_axi_bready,    // Write response ready
  input  wire [7:0]  s_axi_araddr,    // Read address
  input  wire        s_axi_arvalid,   // Read address valid
  output reg         s_axi_arready,   // Read address ready
  output reg  [31:0] s_axi_rdata,     // Read data
  output reg  [1:0]  s_axi_rresp,     // Read response
  output reg         s_axi_rvalid,    // Read data valid
  input  wire        s_axi_rready,    // Read data ready
  input  wire [15:0] drive_checksum,  // Checksum of drive data, same clock
  input  wire [2:0]  drive_mode,      // Drive mode, same clock
  input  wire        rating_mismatch, // Card rating differs, same clock
  input  wire        option_mismatch, // Card options differ, same clock
  output reg         trip,            // Trip level, cleared at drive reset
  output reg  [3:0]  trip_code,       // Trip cause
  output reg         load_pulse       // One cycle, block loaded into drive
);

  localparam N = 8;

  // Card directory, one entry per block
  reg  [N-1:0] d_val;
  reg  [9:0]   d_num  [0:N-1];
  reg  [4:0]   d_typ  [0:N-1];
  reg  [2:0]   d_mode [0:N-1];
  reg  [15:0]  d_sum  [0:N-1];
  reg  [15:0]  d_pg   [0:N-1];

  reg  [15:0] cmd;
  reg  [2:0]  copy;
  reg         copy_chg;
  reg  [15:0] last_blk;
  reg  [9:0]  browse;
  reg  [15:0] pages;
  reg         wp;
  reg         sup;

  // Index of lowest set bit
  function [2:0] first_idx;
    input [N-1:0] v;
    integer k;
    begin
      first_idx = 3'h0;
      for (k = N - 1; k >= 0; k = k - 1) begin
        if (v[k]) begin
          first_idx = k[2:0];
        end
      end
    end
  endfunction

  // Command split into thousands digit and block number
  wire [15:0] quo = cmd / `CB_K;
  wire [15:0] rem = cmd % `CB_K;
  wire [3:0]  dig = (|quo[15:4]) ? 4'h0 : quo[3:0];  // Codes from 16000 up match nothing
  wire [9:0]  yyy = rem[9:0];

  wire [N-1:0] hit_cmd;
  wire [N-1:0] hit_one;
  wire [N-1:0] hit_br;
  wire [N-1:0] ro_v;
  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : g_dir
      assign hit_cmd[g] = d_val[g] && (d_num[g] == yyy);
      assign hit_one[g] = d_val[g] && (d_num[g] == 10'h001);
      assign hit_br[g]  = d_val[g] && (d_num[g] == browse);
      assign ro_v[g]    = d_val[g] && (d_num[g] >= `CB_RO_NUM); // [RL23]
    end
  endgenerate

  // Space accounting, reserved header and tail pages excluded
  reg [15:0] used;
  integer    i;
  integer    j;  // One index per process; a shared one retriggers them
  integer    m;
  always @* begin
    used = 16'h0000;
    for (i = 0; i < N; i = i + 1) begin
      if (d_val[i]) begin
        used = used + d_pg[i];
      end
    end
  end
  wire [15:0] total = pages - `CB_PG_RSV;  // [RL9]
  wire [15:0] freep = total - used;        // [RL5]

  // Browse neighbours among present blocks
  reg [9:0] br_up;
  reg [9:0] br_dn;
  reg [9:0] hi_num;
  always @* begin
    br_up  = `CB_BR_FREE;
    br_dn  = 10'h000;
    hi_num = 10'h000;
    for (j = 0; j < N; j = j + 1) begin
      if (d_val[j] && d_num[j] > browse && d_num[j] < br_up) begin
        br_up = d_num[j];
      end
      if (d_val[j] && d_num[j] < browse && d_num[j] > br_dn) begin
        br_dn = d_num[j];
      end
      if (d_val[j] && d_num[j] > hi_num) begin
        hi_num = d_num[j];
      end
    end
    if (browse >= `CB_BR_FREE) begin  // [RL3]
      br_up = (browse == `CB_BR_ID) ? browse : browse + 10'h001;
      br_dn = (browse == `CB_BR_FREE) ? hi_num : browse - 10'h001;
    end
  end

  // Action decode; only consulted at drive reset
  reg       st_do;
  reg [9:0] st_num;
  reg [4:0] st_typ;
  reg [15:0] st_pg;
  reg       ld_do;
  reg       cmd_act;
  always @* begin
    st_do   = 1'b0;
    st_num  = yyy;
    st_typ  = `CB_T_PAR;
    st_pg   = `CB_PG_PAR;
    ld_do   = 1'b0;
    cmd_act = (cmd != 16'h0000);
    if (cmd == `CB_C_BOOT) begin  // [RL14]
      st_do  = 1'b1;
      st_num = 10'h001;
      st_typ = `CB_T_DIF;
      st_pg  = `CB_PG_DIF;
    end else if (dig == `CB_D_PAR) begin  // [RL15]
      st_do = 1'b1;
    end else if (dig == `CB_D_DIF) begin
      st_do  = 1'b1;
      st_typ = `CB_T_DIF;
      st_pg  = `CB_PG_DIF;
    end else if (dig == `CB_D_PRG) begin
      st_do  = 1'b1;
      st_typ = `CB_T_PRG;
      st_pg  = `CB_PG_PRG;
    end else if (!cmd_act) begin
      st_num = 10'h001;
      if (copy == `CB_M_PROG) begin  // [RL19]
        st_do = 1'b1;
      end
      if ((copy == `CB_M_AUTO || copy == `CB_M_BOOT) && copy_chg) begin
        st_do = 1'b1;  // [RL20]
      end
      if (copy == `CB_M_READ) begin
        ld_do = 1'b1;
      end
    end
  end

  wire       st_hit = |(d_val & (st_num == 10'h001 ? hit_one : hit_cmd));
  wire [2:0] st_old = first_idx(st_num == 10'h001 ? hit_one : hit_cmd);
  wire [2:0] st_new = first_idx(~d_val);
  wire [2:0] st_ix  = st_hit ? st_old : st_new;
  wire [15:0] st_room = freep + (st_hit ? d_pg[st_old] : 16'h0000);
  wire       c_hit  = |hit_cmd;
  wire [2:0] c_ix   = first_idx(hit_cmd);
  wire [2:0] o_ix   = first_idx(hit_one);
  wire [2:0] b_ix   = first_idx(hit_br);

  // AXI write handshake: both channels taken on the same edge
  wire wr_do = s_axi_awready & s_axi_wready;
  wire [7:0] wa = s_axi_awaddr;
  wire [31:0] wd = s_axi_wdata;
  wire wmap = (wa[1:0] == 2'h0) && (wa <= `CB_A_PAGES);
  wire [15:0] wd16 = {s_axi_wstrb[1] ? wd[15:8] : 8'h00,
                      s_axi_wstrb[0] ? wd[7:0] : 8'h00};
  wire w_ctl = wr_do && wa == `CB_A_CTRL && s_axi_wstrb[0];
  wire drv_rst = w_ctl && wd[`CB_B_RST];
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end else if (ce) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      if (s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
      if (wr_do) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wmap ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Browse view, header fields or special values
  reg [31:0] v_first;
  reg [31:0] v_mid;
  reg [31:0] v_last;
  always @* begin
    v_first = {22'h000000, browse};
    v_mid   = 32'h0000_0000;
    v_last  = 32'h0000_0000;
    if (browse == `CB_BR_FREE) begin
      v_first = {16'h0000, freep};  // [RL5]
    end else if (browse == `CB_BR_TOTAL) begin
      v_first = {16'h0000, total};  // [RL6]
    end else if (browse == `CB_BR_FLAGS) begin
      v_first = {30'h00000000, sup, wp};  // [RL7]
    end else if (browse == `CB_BR_ID) begin
      v_first = {16'h0000, CARD_ID};  // [RL8]
    end else if (|hit_br) begin  // [RL4]
      v_first = {22'h000000, d_num[b_ix]};
      v_mid   = {21'h000000, d_mode[b_ix], 3'h0, d_typ[b_ix]};
      v_last  = {8'h00, `CB_VER, d_sum[b_ix]};
    end
  end

  // AXI read channel; unmapped offsets answer SLVERR
  reg [31:0] rd_val;
  always @* begin
    case (s_axi_araddr)
      `CB_A_CMD:    rd_val = {16'h0000, cmd};
      `CB_A_COPY:   rd_val = {29'h00000000, copy};
      `CB_A_CTRL:   rd_val = {24'h000000, trip_code, 1'b0, sup, wp, trip};
      `CB_A_LAST:   rd_val = {16'h0000, last_blk};  // [RL2]
      `CB_A_BROW:   rd_val = {22'h000000, browse};
      `CB_A_VFIRST: rd_val = v_first;
      `CB_A_VMID:   rd_val = v_mid;
      `CB_A_VLAST:  rd_val = v_last;
      `CB_A_MODS:   rd_val = `CB_MODS;  // [RL1]
      `CB_A_PAGES:  rd_val = {16'h0000, pages};
      default:      rd_val = 32'h0000_0000;
    endcase
  end
  wire rmap = (s_axi_araddr[1:0] == 2'h0) && (s_axi_araddr <= `CB_A_PAGES);
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end else if (ce) begin
      s_axi_arready <= 1'b0;
      if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_val;
        s_axi_rresp   <= rmap ? 2'h0 : 2'h2;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Registers and card actions; actions run only at drive reset
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      cmd        <= 16'h0000;
      copy       <= `CB_M_NONE;
      copy_chg   <= 1'b0;
      last_blk   <= 16'h0000;  // [RL2]
      browse     <= 10'h000;
      pages      <= `CB_PG_MIN;
      wp         <= 1'b0;
      sup        <= 1'b0;
      d_val      <= {N{1'b0}};
      trip       <= 1'b0;
      trip_code  <= `CB_TR_NONE;
      load_pulse <= 1'b0;
      for (m = 0; m < N; m = m + 1) begin
        d_num[m]  <= 10'h000;
        d_typ[m]  <= 5'h00;
        d_mode[m] <= 3'h0;
        d_sum[m]  <= 16'h0000;
        d_pg[m]   <= 16'h0000;
      end
    end else if (ce) begin
      load_pulse <= 1'b0;
      if (wr_do && wa == `CB_A_CMD) begin
        cmd <= wd16;  // [RL13]
      end
      if (wr_do && wa == `CB_A_COPY && s_axi_wstrb[0]) begin
        copy     <= wd[2:0];
        copy_chg <= 1'b1;
      end
      if (wr_do && wa == `CB_A_BROW) begin
        browse <= (wd16 > 16'h03eb) ? `CB_BR_ID : wd16[9:0];  // [RL3]
      end
      if (wr_do && wa == `CB_A_PAGES) begin
        if (wd16 >= `CB_PG_MIN && wd16 <= `CB_PG_MAX) begin
          pages <= wd16;  // [RL10]
        end
      end
      if (w_ctl && wd[`CB_B_UP]) begin
        browse <= br_up;  // [RL3]
      end
      if (w_ctl && wd[`CB_B_DOWN]) begin
        browse <= br_dn;
      end
      // New card is taken as blank with clear header flags
      if (w_ctl && wd[`CB_B_INS]) begin
        d_val  <= {N{1'b0}};
        wp     <= 1'b0;
        sup    <= 1'b0;
        browse <= 10'h000;  // [RL12]
      end
      if (w_ctl && wd[`CB_B_MENU0]) begin
        browse <= 10'h000;  // [RL12]
      end
      if (drv_rst) begin  // [RL13]
        trip      <= 1'b0;
        trip_code <= `CB_TR_NONE;
        if (st_do) begin
          // Stores replace an existing block of the same number
          if (st_num == 10'h000) begin
            trip      <= 1'b1;
            trip_code <= `CB_TR_MISS;
          end else if (wp || st_num >= `CB_RO_NUM) begin  // [RL23]
            trip      <= 1'b1;
            trip_code <= `CB_TR_RO;
          end else if ((!st_hit && &d_val) || st_room < st_pg) begin
            trip      <= 1'b1;
            trip_code <= `CB_TR_FULL;
          end else begin
            d_val[st_ix]  <= 1'b1;  // [RL15]
            d_num[st_ix]  <= st_num;
            d_typ[st_ix]  <= st_typ;
            d_mode[st_ix] <= drive_mode;
            d_sum[st_ix]  <= drive_checksum;
            d_pg[st_ix]   <= st_pg;
            browse        <= 10'h000;  // [RL12]
            cmd           <= 16'h0000;
            if (copy == `CB_M_PROG && !cmd_act) begin
              copy <= `CB_M_NONE;
            end
          end
        end else if (ld_do) begin
          // Read copy mode acts only on a parameter file in block 1
          if (|hit_one && d_typ[o_ix] == `CB_T_PAR) begin  // [RL19]
            last_blk   <= 16'h0001;
            load_pulse <= 1'b1;
          end
          copy <= `CB_M_NONE;
        end else if (dig == `CB_D_LOAD) begin  // [RL16]
          if (!c_hit) begin
            trip      <= 1'b1;
            trip_code <= `CB_TR_MISS;
          end else begin
            load_pulse <= 1'b1;
            cmd        <= 16'h0000;
            if (d_typ[c_ix] == `CB_T_PAR || d_typ[c_ix] == `CB_T_DIF) begin
              last_blk <= {6'h00, yyy};  // [RL2]
            end
            if (rating_mismatch && !sup) begin  // [RL11]
              trip      <= 1'b1;
              trip_code <= `CB_TR_RTG;
            end else if (option_mismatch && !sup) begin
              trip      <= 1'b1;
              trip_code <= `CB_TR_OPT;
            end
          end
        end else if (dig == `CB_D_ERASE) begin  // [RL16]
          if (!c_hit) begin
            trip      <= 1'b1;
            trip_code <= `CB_TR_MISS;
          end else if (wp || yyy >= `CB_RO_NUM) begin  // [RL23]
            trip      <= 1'b1;
            trip_code <= `CB_TR_RO;
          end else begin
            d_val[c_ix] <= 1'b0;
            browse      <= 10'h000;  // [RL12]
            cmd         <= 16'h0000;
          end
        end else if (dig == `CB_D_CMP) begin  // [RL21]
          if (!c_hit) begin
            trip      <= 1'b1;
            trip_code <= `CB_TR_MISS;
          end else if (d_typ[c_ix] == `CB_T_OPT) begin
            cmd <= 16'h0000;  // [RL22]
          end else if (d_sum[c_ix] == drive_checksum) begin
            cmd <= 16'h0000;
          end else begin
            trip      <= 1'b1;
            trip_code <= `CB_TR_CMP;
          end
        end else if (cmd == `CB_C_SUPCLR) begin  // [RL17]
          sup <= 1'b0;
          cmd <= 16'h0000;
        end else if (cmd == `CB_C_SUPSET) begin
          sup <= 1'b1;
          cmd <= 16'h0000;
        end else if (cmd == `CB_C_WPCLR) begin  // [RL18]
          wp  <= 1'b0;
          cmd <= 16'h0000;
        end else if (cmd == `CB_C_WPSET) begin
          wp  <= 1'b1;
          cmd <= 16'h0000;
        end else if (cmd == `CB_C_WIPE) begin
          if (wp || |ro_v) begin  // [RL24]
            trip      <= 1'b1;
            trip_code <= `CB_TR_RO;
          end else begin
            d_val  <= {N{1'b0}};
            browse <= 10'h000;  // [RL12]
            cmd    <= 16'h0000;
          end
        end
        // Any other code falls through with card untouched  [RL25]
      end
    end
  end

endmodule // cbtc_top

//--- dv/cbtc_asserts.sv
// Handshake and trip checks for the card transfer block
module cbtc_asserts (
  input logic       ref_clk,       // Clock
  input logic       rst_n,         // Reset, active low
  input logic       s_axi_awready, // Aw ready
  input logic       s_axi_wready,  // W ready
  input logic       s_axi_bvalid,  // B valid
  input logic       s_axi_bready,  // B ready
  input logic       s_axi_arvalid, // Ar valid
  input logic       s_axi_arready, // Ar ready
  input logic       s_axi_rvalid,  // R valid
  input logic       s_axi_rready,  // R ready
  input logic       trip,          // Trip level
  input logic [3:0] trip_code,     // Trip cause
  input logic       load_pulse     // Block loaded
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Fixed bus latency keeps each action in step with the write that starts it
  property p_wr_pair; s_axi_awready |-> s_axi_wready ##1 (s_axi_bvalid && !s_axi_awready); endproperty
  a_wr_pair: assert property (p_wr_pair) else $error("write accept out of step");
  property p_b_drop; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_b_drop: assert property (p_b_drop) else $error("write response held too long");
  property p_rd_answer;
    s_axi_arvalid && !s_axi_arready && !s_axi_rvalid |=> s_axi_arready && s_axi_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered next cycle");
  property p_r_drop; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && !s_axi_arready; endproperty
  a_r_drop: assert property (p_r_drop) else $error("read response held too long");
  // A trip names its cause, and only moves in the cycle after a write is accepted
  property p_trip_code; trip |-> trip_code inside {[4'h1:4'h6]}; endproperty
  a_trip_code: assert property (p_trip_code) else $error("trip without cause");
  property p_trip_cause; $changed(trip) |-> $past(s_axi_wready); endproperty
  a_trip_cause: assert property (p_trip_cause) else $error("trip moved without a write");
  property p_load; load_pulse |-> $past(s_axi_wready) ##1 !load_pulse; endproperty
  a_load: assert property (p_load) else $error("load pulse misplaced");
  property p_load_trip; load_pulse && trip |-> trip_code == 4'h5 || trip_code == 4'h6; endproperty
  a_load_trip: assert property (p_load_trip) else $error("wrong trip on load");
  c_load: cover property (load_pulse);
  c_cmp: cover property (trip && trip_code == 4'h4);
  c_ro: cover property (trip && trip_code == 4'h2);
endmodule // cbtc_asserts

bind cbtc_top cbtc_asserts u_chk (.ref_clk, .rst_n, .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .trip, .trip_code, .load_pulse);

//--- dv/cbtc_drive_model.sv
// Drive-side data source seen by the card transfer block
module cbtc_drive_model #(
  parameter logic [2:0] MODE = 3'h2 // Drive mode reported to the block
) (
  input  logic        ref_clk,         // Clock
  input  logic        rst_n,           // Sync reset, active low
  input  logic        edit,            // Parameter edit strobe
  input  logic        rtg,             // Rating differs request
  input  logic        opt,             // Options differ request
  output logic [15:0] drive_checksum,  // Checksum of drive data
  output logic [2:0]  drive_mode,      // Drive mode
  output logic        rating_mismatch, // Card rating differs
  output logic        option_mismatch  // Card options differ
);
  timeunit 1ns;
  timeprecision 1ns;
  // An edit moves the checksum, so a later compare must fail
  always_ff @(posedge ref_clk) begin
    rating_mismatch <= rtg;
    option_mismatch <= opt;
    if (!rst_n)
      drive_checksum <= 16'h1c3a;
    else if (edit)
      drive_checksum <= drive_checksum + 16'h0001;
  end
  assign drive_mode = MODE;
endmodule // cbtc_drive_model

//--- dv/tb_top.sv
// Register-level test of the card transfer block
`include "cbtc_map.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] ID = 16'h3c71; // Arbitrary product identifier
  localparam logic [15:0] TOT = `CB_PG_MIN - `CB_PG_RSV;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  aa = 8'h0, ra = 8'h0;
  logic [31:0] wd = 32'h0, rd;
  logic        av = 1'b0, wv = 1'b0, bb = 1'b0, arv = 1'b0, rr = 1'b0;
  logic        edit = 1'b0, rtg = 1'b0, opt = 1'b0;
  logic        awr, wr, bv, arr, rv, trip, lp, rtm, opm;
  logic [1:0]  br, rre;
  logic [3:0]  tcode;
  logic [15:0] dcs, fr;
  logic [2:0]  dmo;
  logic [15:0] stp [4] = '{16'h2, 16'h5, 16'h7, 16'h3e8};
  int          n_mismatch = 0, compares = 0;
  // Clock, 40 ns period
  always #20 ref_clk = ~ref_clk;
  cbtc_drive_model drv (.ref_clk, .rst_n, .edit, .rtg, .opt, .drive_checksum(dcs), .drive_mode(dmo),
    .rating_mismatch(rtm), .option_mismatch(opm));
  // Clock enable held high; freezing is not exercised here
  cbtc_top #(.CARD_ID(ID)) dut (.ref_clk, .rst_n, .ce(1'b1), .s_axi_awaddr(aa), .s_axi_awvalid(av),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bb), .s_axi_araddr(ra), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rre), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .drive_checksum(dcs), .drive_mode(dmo), .rating_mismatch(rtm), .option_mismatch(opm), .trip,
    .trip_code(tcode), .load_pulse(lp));
  task results;
    if (n_mismatch == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task tmo;
    n_mismatch++;
    $display("mismatch %0t wait ran out", $time);
    results;
  endtask
  // Address and data offered together, released only once taken
  task axw(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    aa <= a;
    wd <= d;
    av <= 1'b1;
    wv <= 1'b1;
    bb <= 1'b1;
    for (n = 0; n < 20 && awr !== 1'b1; n++) @(posedge ref_clk);
    if (awr !== 1'b1) tmo;
    av <= 1'b0;
    wv <= 1'b0;
    for (n = 0; n < 20 && bv !== 1'b1; n++) @(posedge ref_clk);
    if (bv !== 1'b1) tmo;
    bb <= 1'b0;
  endtask
  // Read and compare data and response code
  task chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
    int n;
    @(posedge ref_clk);
    ra <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    for (n = 0; n < 20 && rv !== 1'b1; n++) @(posedge ref_clk);
    if (rv !== 1'b1) tmo;
    arv <= 1'b0;
    rr <= 1'b0;
    compares++;
    if (rd !== e || rre !== er) begin
      n_mismatch++;
      $display("mismatch %0t at %h read %h", $time, a, rd);
    end
  endtask
  task vw(input logic [9:0] i, input logic [15:0] e);
    axw(`CB_A_BROW, {22'h0, i});
    chk(`CB_A_VFIRST, {16'h0, e});
  endtask
  // Command code, then drive reset
  task act(input logic [15:0] c);
    axw(`CB_A_CMD, {16'h0, c});
    axw(`CB_A_CTRL, 32'h1);
  endtask
  function logic [15:0] cc(input int d, input int b);
    return 16'(d * `CB_K + b);
  endfunction
  function logic [31:0] st(input logic [3:0] c, input logic wp, input logic sp);
    return {24'h0, c, 1'b0, sp, wp, c != 4'h0};
  endfunction
  initial begin
    repeat (90000) @(posedge ref_clk);
    tmo;
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    chk(`CB_A_LAST, 32'h0);
    chk(`CB_A_MODS, `CB_MODS);
    chk(8'h28, 32'h0, 2'h2);
    vw(`CB_BR_TOTAL, TOT);
    vw(`CB_BR_FREE, TOT);
    vw(`CB_BR_FLAGS, 16'h0);
    vw(`CB_BR_ID, ID);
    axw(`CB_A_BROW, 32'h3ec);
    chk(`CB_A_BROW, 32'h3eb);
    axw(`CB_A_CMD, {16'h0, cc(3, 5)});
    vw(`CB_BR_FREE, TOT);
    axw(`CB_A_CTRL, 32'h1);
    chk(`CB_A_CMD, 32'h0);
    act(cc(4, 7));
    act(cc(5, 2));
    fr = TOT - `CB_PG_PAR - `CB_PG_DIF - `CB_PG_PRG;
    vw(`CB_BR_FREE, fr);
    axw(`CB_A_BROW, 32'h0);
    for (int k = 0; k < 4; k++) begin
      axw(`CB_A_CTRL, 32'h8);
      chk(`CB_A_BROW, {16'h0, stp[k]});
    end
    axw(`CB_A_CTRL, 32'h10);
    chk(`CB_A_BROW, 32'h7);
    vw(10'h5, 16'h5);
    chk(`CB_A_VMID, {21'h0, dmo, 3'h0, `CB_T_PAR});
    chk(`CB_A_VLAST, {8'h0, `CB_VER, dcs});
    act(`CB_C_BOOT);
    vw(10'h1, 16'h1);
    chk(`CB_A_VMID, {21'h0, dmo, 3'h0, `CB_T_DIF});
    act(cc(6, 5));
    act(cc(6, 2));
    chk(`CB_A_LAST, 32'h5);
    rtg <= 1'b1;
    act(cc(6, 7));
    chk(`CB_A_CTRL, st(`CB_TR_RTG, 1'b0, 1'b0));
    chk(`CB_A_LAST, 32'h7);
    act(`CB_C_SUPSET);
    vw(`CB_BR_FLAGS, 16'h2);
    act(cc(6, 7));
    chk(`CB_A_CTRL, st(4'h0, 1'b0, 1'b1));
    rtg <= 1'b0;
    opt <= 1'b1;
    act(`CB_C_SUPCLR);
    act(cc(6, 7));
    chk(`CB_A_CTRL, st(`CB_TR_OPT, 1'b0, 1'b0));
    opt <= 1'b0;
    act(cc(8, 5));
    chk(`CB_A_CMD, 32'h0);
    edit <= 1'b1;
    @(posedge ref_clk);
    edit <= 1'b0;
    act(cc(8, 5));
    chk(`CB_A_CTRL, st(`CB_TR_CMP, 1'b0, 1'b0));
    chk(`CB_A_CMD, {16'h0, cc(8, 5)});
    act(cc(3, 500));
    chk(`CB_A_CTRL, st(`CB_TR_RO, 1'b0, 1'b0));
    act(cc(3, 499));
    chk(`CB_A_CMD, 32'h0);
    fr = fr - `CB_PG_DIF - `CB_PG_PAR;
    act(cc(1, 111));
    act(cc(19, 5));
    vw(`CB_BR_FREE, fr);
    act(`CB_C_WPSET);
    vw(`CB_BR_FLAGS, 16'h1);
    act(`CB_C_WIPE);
    chk(`CB_A_CTRL, st(`CB_TR_RO, 1'b1, 1'b0));
    act(`CB_C_WPCLR);
    vw(`CB_BR_FLAGS, 16'h0);
    axw(`CB_A_BROW, 32'h3e9);
    act(cc(7, 499));
    chk(`CB_A_BROW, 32'h0);
    vw(`CB_BR_FREE, fr + `CB_PG_PAR);
    act(`CB_C_WIPE);
    vw(`CB_BR_FREE, TOT);
    axw(`CB_A_COPY, {29'h0, `CB_M_PROG});
    axw(`CB_A_CTRL, 32'h1);
    vw(10'h1, 16'h1);
    chk(`CB_A_VMID, {21'h0, dmo, 3'h0, `CB_T_PAR});
    axw(`CB_A_COPY, {29'h0, `CB_M_READ});
    axw(`CB_A_CTRL, 32'h1);
    chk(`CB_A_LAST, 32'h1);
    act(cc(7, 1));
    axw(`CB_A_COPY, {29'h0, `CB_M_AUTO});
    axw(`CB_A_CTRL, 32'h1);
    vw(10'h1, 16'h1);
    chk(`CB_A_VMID, {21'h0, dmo, 3'h0, `CB_T_PAR});
    axw(`CB_A_COPY, {29'h0, `CB_M_BOOT});
    act(cc(7, 1));
    axw(`CB_A_CTRL, 32'h1);
    vw(10'h1, 16'h1);
    chk(`CB_A_VMID, {21'h0, dmo, 3'h0, `CB_T_PAR});
    axw(`CB_A_PAGES, {16'h0, `CB_PG_MAX});
    vw(`CB_BR_TOTAL, `CB_PG_MAX - `CB_PG_RSV);
    axw(`CB_A_PAGES, 32'h8001);
    chk(`CB_A_PAGES, {16'h0, `CB_PG_MAX});
    axw(`CB_A_CTRL, 32'h2);
    chk(`CB_A_BROW, 32'h0);
    vw(`CB_BR_FREE, `CB_PG_MAX - `CB_PG_RSV);
    axw(`CB_A_CTRL, 32'h4);
    chk(`CB_A_BROW, 32'h0);
    results;
  end
endmodule // tb_top
